// ==== rtl/fcct_chan.sv ====
/*
 * One timer channel: capture or compare, with a flag and a pin output.
 * Assumes a synchronised pin level and one-cycle tick and overflow pulses.
 */
`timescale 1ns/10ps
`include "fcct_map.svh"
module fcct_chan
	import fcct_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	fcct_tick_if.dst        tb,
	// Configuration
	input  wire logic       capture_mode,
	input  wire logic [1:0] edge_sel,
	input  wire logic [1:0] action,
	input  wire logic       tov_en,
	input  wire logic [15:0] cmp_value,
	// Pin and capture
	input  wire logic       pin_sync,
	output logic            cap_stb,
	output logic            flag_set,
	output logic            pin_out
);
	logic pin_d_r;
	logic pin_d_nxt;
	logic pin_out_r;
	logic pin_out_nxt;
	logic rise;
	logic fall;
	logic match;
	logic [15:0] cnt_next;

	// Edge detection and compare events.
	// The match acts on the count being entered, so with clear on compare the pulse width equals the value.
	always_comb begin
		cnt_next = tb.ovf ? `FCCT_CNT_RST : tb.count + 16'h0001;
		rise = pin_sync & ~pin_d_r;
		fall = ~pin_sync & pin_d_r;
		cap_stb = capture_mode & (((edge_sel == `FCCT_EDGE_RISE) & rise) |
			((edge_sel == `FCCT_EDGE_FALL) & fall) |
			((edge_sel == `FCCT_EDGE_ANY) & (rise | fall)));
		match = ~capture_mode & tb.tick & (cnt_next == cmp_value);
		flag_set = cap_stb | match;
		pin_d_nxt = pin_sync;
		pin_out_nxt = pin_out_r;
		if (match) begin
			unique case (action)
				`FCCT_ACT_TOGGLE: pin_out_nxt = ~pin_out_r;
				`FCCT_ACT_CLEAR:  pin_out_nxt = 1'b0;
				`FCCT_ACT_SET:    pin_out_nxt = 1'b1;
				default:          pin_out_nxt = pin_out_r;
			endcase
		end else if (~capture_mode & tov_en & tb.ovf) begin
			pin_out_nxt = ~pin_out_r;
		end
		if (capture_mode) begin
			pin_out_nxt = 1'b0;
		end
	end

	// Registered state; a compare at the wrap wins over the overflow toggle.
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_d_r   <= 1'b0;
			pin_out_r <= 1'b0;
		end else begin
			pin_d_r   <= pin_d_nxt;
			pin_out_r <= pin_out_nxt;
		end
	end

	assign pin_out = pin_out_r;
endmodule

// ==== rtl/fcct_map.svh ====
/*
 * Constants for the four channel capture compare timer: field codes, reset values and
 * widths, as text macros.
 * Assumes it is included by its bare name from files that use the constants.
 */
`ifndef FCCT_MAP_SVH
`define FCCT_MAP_SVH

// ****************************************************************
// Encodings
// ****************************************************************
`define FCCT_SEL_EXT      3'h7
`define FCCT_ACT_NONE     2'h0
`define FCCT_ACT_TOGGLE   2'h1
`define FCCT_ACT_CLEAR    2'h2
`define FCCT_ACT_SET      2'h3
`define FCCT_EDGE_NONE    2'h0
`define FCCT_EDGE_RISE    2'h1
`define FCCT_EDGE_FALL    2'h2
`define FCCT_EDGE_ANY     2'h3

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define FCCT_CNT_RST      16'h0000
`define FCCT_MOD_RST      16'hFFFF
`define FCCT_PRE_W        7
`define FCCT_NCH          4

`endif

// ==== rtl/fcct_pkg.sv ====
/*
 * Types of the four channel capture compare timer.
 * Assumes the map header is compiled alongside.
 */
package fcct_pkg;
	typedef logic [15:0] fcct_word_t;
	typedef logic [2:0]  fcct_sel_t;
	typedef logic [1:0]  fcct_act_t;
	typedef enum logic [1:0] {
		FCCT_ACT0 = 2'h1,
		FCCT_ACT1 = 2'h2
	} fcct_owner_t;
endpackage

// ==== rtl/fcct_tick_if.sv ====
/*
 * Carrier for the shared time base from the counter to the channels.
 * Assumes a single clock domain.
 */
`timescale 1ns/10ps
interface fcct_tick_if;
	logic [15:0] count;
	logic        tick;
	logic        ovf;
	modport src (output count, output tick, output ovf);
	modport dst (input count, input tick, input ovf);
endinterface

// ==== rtl/fcct_top.sv ====
/*
 * Four channel capture compare timer with prescaler, modulo counter and buffered pairs.
 * Assumes software writes come as one-cycle strobes on CLK and pins are asynchronous.
 */
`timescale 1ns/10ps
`include "fcct_map.svh"
module fcct_top
	import fcct_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        SRST,
	// Time base control
	input  wire logic [2:0]  CLOCK_SOURCE_SELECT,
	input  wire logic [15:0] MODULO_LIMIT,
	input  wire logic        EXT_COUNT_CLOCK_PIN,
	// Channel configuration, one field per channel, then the overflow enable and one link bit per pair
	input  wire logic [3:0]  CAPTURE_MODE,
	input  wire logic [7:0]  EDGE_SEL,
	input  wire logic [7:0]  COMPARE_ACTION,
	input  wire logic [3:0]  TOGGLE_ON_OVERFLOW_BIT,
	input  wire logic [3:0]  CHANNEL_IE,
	input  wire logic        OVERFLOW_IE,
	input  wire logic        PAIR01_LINK_BIT,
	input  wire logic        PAIR23_LINK_BIT,
	// Channel value writes
	input  wire logic [3:0]  VALUE_WR,
	input  wire logic [15:0] VALUE_WDATA,
	// Flag clears
	input  wire logic [3:0]  CHANNEL_FLAG_CLR,
	input  wire logic        OVERFLOW_FLAG_CLR,
	// Channel pins
	input  wire logic [3:0]  CHANNEL_PIN_IN,
	output logic [3:0]       CHANNEL_PIN_OUT,
	output logic [3:0]       CHANNEL_PIN_OE,
	// Status
	output logic [15:0]      COUNT_VALUE,
	output logic [63:0]      CHANNEL_VALUE,
	output logic [3:0]       CHANNEL_EVENT_FLAG,
	output logic             OVERFLOW_FLAG,
	output logic [3:0]       CHANNEL_IRQ,
	output logic             OVERFLOW_IRQ,
	output logic [1:0]       PAIR_ACTIVE_SECOND
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	fcct_tick_if tb ();

	logic [3:0]  pin_s1_r;
	logic [3:0]  pin_s2_r;
	logic        ext_s1_r;
	logic        ext_s2_r;
	logic        ext_d_r;
	logic [6:0]  pre_r;
	logic [6:0]  pre_nxt;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic        tick;
	logic        ovf;
	logic [15:0] val_r [4];
	logic [15:0] val_nxt [4];
	logic [15:0] cmp_val [4];
	logic [3:0]  cap_stb;
	logic [3:0]  flag_set;
	logic [3:0]  ch_pin;
	logic [3:0]  flag_r;
	logic [3:0]  flag_nxt;
	logic        tof_r;
	logic        tof_nxt;
	logic [1:0]  link;
	logic [3:0]  cap_eff;
	logic [3:0]  pin_r;
	logic [3:0]  pin_nxt;
	logic [3:0]  oe_r;
	logic [3:0]  oe_nxt;
	logic [15:0] cout_r;
	logic [3:0]  irq_r;
	logic [3:0]  irq_nxt;
	logic        oirq_r;
	logic        oirq_nxt;

	// Buffered pair ownership state, one machine per pair.
	fcct_owner_t own_r [2];
	fcct_owner_t own_nxt [2];
	logic [1:0]  pend_r;
	logic [1:0]  pend_nxt;
	fcct_owner_t pend_to_r [2];
	fcct_owner_t pend_to_nxt [2];

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Two flops before any logic; only the second stage and the external clock's third flop are observed.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pin_s1_r <= 4'h0;
			pin_s2_r <= 4'h0;
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_d_r  <= 1'b0;
		end else begin
			pin_s1_r <= CHANNEL_PIN_IN;
			pin_s2_r <= pin_s1_r;
			ext_s1_r <= EXT_COUNT_CLOCK_PIN;
			ext_s2_r <= ext_s1_r;
			ext_d_r  <= ext_s2_r;
		end
	end

	// ****************************************************************
	// Prescaler and counter
	// ****************************************************************
	// The prescaler is a free binary divider; a tap rises once per 2^n bus clocks.
	// Select zero ticks every cycle; the external pin ticks on its synchronised
	// rising edge, so it must stay below half the bus rate.
	always_comb begin
		pre_nxt = pre_r + 7'h01;
		if (CLOCK_SOURCE_SELECT == `FCCT_SEL_EXT) begin
			tick = ext_s2_r & ~ext_d_r;
		end else if (CLOCK_SOURCE_SELECT == 3'h0) begin
			tick = 1'b1;
		end else begin
			tick = (pre_r & ((7'h01 << CLOCK_SOURCE_SELECT) - 7'h01)) == 7'h00;
		end
		ovf = tick & (cnt_r == MODULO_LIMIT);
		cnt_nxt = cnt_r;
		if (ovf) begin
			cnt_nxt = `FCCT_CNT_RST;
		end else if (tick) begin
			cnt_nxt = cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			pre_r <= 7'h00;
			cnt_r <= `FCCT_CNT_RST;
		end else begin
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign tb.count = cnt_r;
	assign tb.tick  = tick;
	assign tb.ovf   = ovf;

	// ****************************************************************
	// Channel value registers and pair ownership
	// ****************************************************************
	// A write to the inactive half arms a handover taken at the next overflow;
	// writing the active half updates it in place and cancels any armed handover.
	assign link = {PAIR23_LINK_BIT, PAIR01_LINK_BIT};

	always_comb begin
		for (int i = 0; i < `FCCT_NCH; i++) begin
			val_nxt[i] = val_r[i];
			if (cap_stb[i]) begin
				val_nxt[i] = cnt_r;
			end else if (VALUE_WR[i]) begin
				val_nxt[i] = VALUE_WDATA;
			end
		end
		for (int p = 0; p < 2; p++) begin
			own_nxt[p]     = own_r[p];
			pend_nxt[p]    = pend_r[p];
			pend_to_nxt[p] = pend_to_r[p];
			if (!link[p]) begin
				own_nxt[p]  = FCCT_ACT0;
				pend_nxt[p] = 1'b0;
			end else begin
				if (ovf && pend_r[p]) begin
					own_nxt[p]  = pend_to_r[p];
					pend_nxt[p] = 1'b0;
				end
				if (VALUE_WR[2*p+1]) begin
					pend_nxt[p]    = (own_nxt[p] != FCCT_ACT1);
					pend_to_nxt[p] = FCCT_ACT1;
				end else if (VALUE_WR[2*p]) begin
					pend_nxt[p]    = (own_nxt[p] != FCCT_ACT0);
					pend_to_nxt[p] = FCCT_ACT0;
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			for (int i = 0; i < `FCCT_NCH; i++) begin
				val_r[i] <= 16'h0000;
			end
			for (int p = 0; p < 2; p++) begin
				own_r[p]     <= FCCT_ACT0;
				pend_to_r[p] <= FCCT_ACT0;
			end
			pend_r <= 2'h0;
		end else begin
			val_r     <= val_nxt;
			own_r     <= own_nxt;
			pend_r    <= pend_nxt;
			pend_to_r <= pend_to_nxt;
		end
	end

	// Compare value seen by each channel; a linked first channel uses its owner.
	always_comb begin
		for (int i = 0; i < `FCCT_NCH; i++) begin
			cmp_val[i] = val_r[i];
			cap_eff[i] = CAPTURE_MODE[i];
		end
		for (int p = 0; p < 2; p++) begin
			if (link[p]) begin
				cmp_val[2*p] = (own_r[p] == FCCT_ACT1) ? val_r[2*p+1] : val_r[2*p];
				cap_eff[2*p]   = 1'b0;
				cap_eff[2*p+1] = 1'b1;
			end
		end
	end

	// ****************************************************************
	// Channels
	// ****************************************************************
	// Disturbance after an unsynchronised value change is accepted as is.
	genvar g;
	generate
		for (g = 0; g < `FCCT_NCH; g++) begin : g_ch
			fcct_chan u_ch (
				.clk          (CLK),
				.srst         (SRST),
				.tb           (tb),
				.capture_mode (cap_eff[g]),
				.edge_sel     (EDGE_SEL[2*g+1:2*g]),
				.action       (COMPARE_ACTION[2*g+1:2*g]),
				.tov_en       (TOGGLE_ON_OVERFLOW_BIT[g]),
				.cmp_value    (cmp_val[g]),
				.pin_sync     (pin_s2_r[g]),
				.cap_stb      (cap_stb[g]),
				.flag_set     (flag_set[g]),
				.pin_out      (ch_pin[g])
			);
		end
	endgenerate

	// ****************************************************************
	// Flags, interrupts and pin drive
	// ****************************************************************
	// Set wins over clear so no event is lost; a linked second channel reports only while its CAPTURE_MODE bit is set.
	always_comb begin
		flag_nxt = flag_r & ~CHANNEL_FLAG_CLR;
		for (int i = 0; i < `FCCT_NCH; i++) begin
			if (flag_set[i] && !(link[i/2] && (i % 2 == 1) && !CAPTURE_MODE[i])) begin
				flag_nxt[i] = 1'b1;
			end
		end
		for (int p = 0; p < 2; p++) begin
			if (link[p] && !CAPTURE_MODE[2*p+1]) begin
				flag_nxt[2*p+1] = 1'b0;
			end
		end
		tof_nxt = (tof_r & ~OVERFLOW_FLAG_CLR) | ovf;
		irq_nxt  = flag_nxt & CHANNEL_IE;
		oirq_nxt = tof_nxt & OVERFLOW_IE;
		oe_nxt   = ~cap_eff;
		pin_nxt  = ch_pin;
	end

	// Output registers; the count copy is read-only and never feeds the counter.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			flag_r <= 4'h0;
			tof_r  <= 1'b0;
			irq_r  <= 4'h0;
			oirq_r <= 1'b0;
			oe_r   <= 4'h0;
			pin_r  <= 4'h0;
			cout_r <= 16'h0000;
		end else begin
			flag_r <= flag_nxt;
			tof_r  <= tof_nxt;
			irq_r  <= irq_nxt;
			oirq_r <= oirq_nxt;
			oe_r   <= oe_nxt;
			pin_r  <= pin_nxt;
			cout_r <= cnt_nxt;
		end
	end

	assign COUNT_VALUE        = cout_r;
	assign CHANNEL_VALUE      = {val_r[3], val_r[2], val_r[1], val_r[0]};
	assign CHANNEL_EVENT_FLAG = flag_r;
	assign OVERFLOW_FLAG      = tof_r;
	assign CHANNEL_IRQ        = irq_r;
	assign OVERFLOW_IRQ       = oirq_r;
	assign CHANNEL_PIN_OUT    = pin_r;
	assign CHANNEL_PIN_OE     = oe_r;
	assign PAIR_ACTIVE_SECOND = {own_r[1] == FCCT_ACT1, own_r[0] == FCCT_ACT1};
endmodule

// ==== sim/fcct_pin_model.sv ====
/*
 * Far side of the channel pins: event sources with pull-ups and the external count clock.
 * Assumes the bench calls its tasks and that the timer drives a pin only while enabled.
 */
`timescale 1ns/10ps
module fcct_pin_model (
	// Clock
	input  wire logic       clk,
	// Timer side of the pins
	input  wire logic [3:0] pin_out,
	input  wire logic [3:0] pin_oe,
	output logic [3:0]      pin_in,
	output logic            ext_clk
);
	logic [3:0] src_r = 4'hF;

	initial ext_clk = 1'b0;

	// Pull-ups hold a source that is not driven, so the level is never left to chance.
	always_comb begin
		pin_in = (pin_oe & pin_out) | (~pin_oe & src_r);
	end

	// Pulses stay at a ninth of the bus rate, well within the external clock limit.
	task automatic ext_pulses(input int k);
		repeat (k) begin
			@(posedge clk);
			ext_clk <= 1'b1;
			repeat (4) @(posedge clk);
			ext_clk <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask

	task automatic set_src(input int ch, input logic lvl);
		@(posedge clk);
		src_r[ch] <= lvl;
	endtask
endmodule

// ==== sim/fcct_top_properties.sv ====
/*
 * Concurrent checks on the timer's top-level ports, bound into every instance.
 * Assumes one clock domain with a synchronous active-high reset.
 */
`timescale 1ns/10ps
module fcct_top_properties (
	// Clock and reset
	input wire logic        CLK,
	input wire logic        SRST,
	// Configuration
	input wire logic [2:0]  CLOCK_SOURCE_SELECT,
	input wire logic [15:0] MODULO_LIMIT,
	input wire logic [3:0]  CAPTURE_MODE,
	input wire logic [7:0]  COMPARE_ACTION,
	input wire logic [3:0]  TOGGLE_ON_OVERFLOW_BIT,
	input wire logic [3:0]  CHANNEL_IE,
	input wire logic        PAIR01_LINK_BIT,
	input wire logic [3:0]  VALUE_WR,
	input wire logic        OVERFLOW_FLAG_CLR,
	// Observed outputs
	input wire logic [3:0]  CHANNEL_PIN_OUT,
	input wire logic [3:0]  CHANNEL_PIN_OE,
	input wire logic [15:0] COUNT_VALUE,
	input wire logic [63:0] CHANNEL_VALUE,
	input wire logic [3:0]  CHANNEL_EVENT_FLAG,
	input wire logic        OVERFLOW_FLAG,
	input wire logic [3:0]  CHANNEL_IRQ
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	// Two samples at select zero, so a late prescaler cannot hide a tick.
	sequence s_tick0;
		(CLOCK_SOURCE_SELECT == 3'h0) [*2];
	endsequence
	// Channel 0 alone in compare mode, count on its value, no write racing it.
	sequence s_ch0_hit;
		s_tick0 ##0 (!CAPTURE_MODE[0] && !PAIR01_LINK_BIT && !VALUE_WR[0]
			&& $stable({CHANNEL_VALUE[15:0], COMPARE_ACTION[1:0], PAIR01_LINK_BIT})
			&& COUNT_VALUE == CHANNEL_VALUE[15:0]);
	endsequence

	property p_count_step;
		s_tick0 ##0 (COUNT_VALUE != MODULO_LIMIT) |=> COUNT_VALUE == $past(COUNT_VALUE) + 16'h1;
	endproperty
	property p_wrap;
		s_tick0 ##0 (COUNT_VALUE == MODULO_LIMIT) |=> COUNT_VALUE == 16'h0 && OVERFLOW_FLAG;
	endproperty
	property p_ovf_hold;
		OVERFLOW_FLAG && !OVERFLOW_FLAG_CLR |=> OVERFLOW_FLAG;
	endproperty
	property p_ovf_at_zero;
		$rose(OVERFLOW_FLAG) |-> COUNT_VALUE == 16'h0;
	endproperty
	property p_cmp_set;
		s_ch0_hit ##0 (COMPARE_ACTION[1:0] == 2'h3) |=> CHANNEL_PIN_OUT[0] && CHANNEL_EVENT_FLAG[0];
	endproperty
	property p_cmp_clr;
		s_ch0_hit ##0 (COMPARE_ACTION[1:0] == 2'h2) |=> !CHANNEL_PIN_OUT[0];
	endproperty
	property p_tov;
		s_tick0 ##0 (!CAPTURE_MODE[0] && !PAIR01_LINK_BIT && !VALUE_WR[0]
			&& TOGGLE_ON_OVERFLOW_BIT[0] && COUNT_VALUE == MODULO_LIMIT
			&& CHANNEL_VALUE[15:0] != 16'h0000 && CHANNEL_VALUE[15:0] != MODULO_LIMIT)
			|-> ##2 CHANNEL_PIN_OUT[0] != $past(CHANNEL_PIN_OUT[0], 2);
	endproperty
	property p_link_release;
		PAIR01_LINK_BIT |=> !CHANNEL_PIN_OE[1];
	endproperty
	property p_irq;
		CHANNEL_IRQ == (CHANNEL_EVENT_FLAG & $past(CHANNEL_IE));
	endproperty

	a_count_step: assert property (p_count_step) else $error("count did not step by one");
	a_wrap: assert property (p_wrap) else $error("count did not wrap at modulo");
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");
	a_ovf_at_zero: assert property (p_ovf_at_zero) else $error("overflow flag off wrap");
	a_cmp_set: assert property (p_cmp_set) else $error("compare set missed");
	a_cmp_clr: assert property (p_cmp_clr) else $error("compare clear missed");
	a_tov: assert property (p_tov) else $error("no toggle at overflow");
	a_link_release: assert property (p_link_release) else $error("linked pin driven");
	a_irq: assert property (p_irq) else $error("request differs from flag and enable");
endmodule

bind fcct_top fcct_top_properties chk (
	.CLK(CLK), .SRST(SRST), .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT),
	.MODULO_LIMIT(MODULO_LIMIT), .CAPTURE_MODE(CAPTURE_MODE), .COMPARE_ACTION(COMPARE_ACTION),
	.TOGGLE_ON_OVERFLOW_BIT(TOGGLE_ON_OVERFLOW_BIT), .CHANNEL_IE(CHANNEL_IE),
	.PAIR01_LINK_BIT(PAIR01_LINK_BIT), .VALUE_WR(VALUE_WR), .OVERFLOW_FLAG_CLR(OVERFLOW_FLAG_CLR),
	.CHANNEL_PIN_OUT(CHANNEL_PIN_OUT), .CHANNEL_PIN_OE(CHANNEL_PIN_OE),
	.COUNT_VALUE(COUNT_VALUE), .CHANNEL_VALUE(CHANNEL_VALUE),
	.CHANNEL_EVENT_FLAG(CHANNEL_EVENT_FLAG), .OVERFLOW_FLAG(OVERFLOW_FLAG),
	.CHANNEL_IRQ(CHANNEL_IRQ)
);

// ==== sim/four_channel_capture_compare_timer_test.sv ====
/*
 * Self-checking bench: reset, external clock, capture, wrap, prescaler, PWM, buffered pairs.
 * Assumes the pin model and the property checker are compiled before it.
 */
`timescale 1ns/10ps
module four_channel_capture_compare_timer_test;
	import fcct_pkg::*;
	// ****************************************************************
	// Stimulus and observation
	// ****************************************************************
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [2:0]  sel = 3'h7;
	logic [15:0] modl = 16'hFFFF;
	logic [15:0] wdata = 16'h0000;
	logic [7:0]  edg = 8'h00;
	logic [7:0]  act = 8'h00;
	logic [3:0]  capm = 4'h0;
	logic [3:0]  tov = 4'h0;
	logic [3:0]  cie = 4'h0;
	logic [3:0]  wr = 4'h0;
	logic [3:0]  fclr = 4'h0;
	logic [1:0]  lnk = 2'h0;
	logic        oie = 1'b0;
	logic        oclr = 1'b0;
	logic        ext, ovf, oirq;
	logic [3:0]  pin_in, pin_out, pin_oe, flag, irq;
	logic [15:0] cnt;
	logic [63:0] chv;
	logic [1:0]  pas;
	int          failures = 0;
	int          total_checks = 0;
	int          hi, per, n, e;
	// PWM cases: action, value, toggle on overflow, high time, period.
	int          t_act[3] = '{2, 3, 1};
	int          t_val[3] = '{128, 64, 128};
	int          t_tov[3] = '{1, 1, 0};
	int          t_hi[3] = '{128, 192, 256};
	int          t_per[3] = '{256, 256, 512};

	always #10 clk = ~clk;

	fcct_top uut (
		.CLK(clk), .SRST(srst), .CLOCK_SOURCE_SELECT(sel), .MODULO_LIMIT(modl),
		.EXT_COUNT_CLOCK_PIN(ext), .CAPTURE_MODE(capm), .EDGE_SEL(edg),
		.COMPARE_ACTION(act), .TOGGLE_ON_OVERFLOW_BIT(tov), .CHANNEL_IE(cie),
		.OVERFLOW_IE(oie), .PAIR01_LINK_BIT(lnk[0]), .PAIR23_LINK_BIT(lnk[1]),
		.VALUE_WR(wr), .VALUE_WDATA(wdata), .CHANNEL_FLAG_CLR(fclr),
		.OVERFLOW_FLAG_CLR(oclr), .CHANNEL_PIN_IN(pin_in), .CHANNEL_PIN_OUT(pin_out),
		.CHANNEL_PIN_OE(pin_oe), .COUNT_VALUE(cnt), .CHANNEL_VALUE(chv),
		.CHANNEL_EVENT_FLAG(flag), .OVERFLOW_FLAG(ovf), .CHANNEL_IRQ(irq),
		.OVERFLOW_IRQ(oirq), .PAIR_ACTIVE_SECOND(pas)
	);
	fcct_pin_model pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
		.ext_clk(ext));

	// ****************************************************************
	// Access and compare tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic ticks(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic wr_val(input int ch, input logic [15:0] v);
		@(posedge clk);
		wr <= 4'h1 << ch;
		wdata <= v;
		@(posedge clk);
		wr <= 4'h0;
	endtask

	task automatic clr_flags;
		@(posedge clk);
		fclr <= 4'hF;
		oclr <= 1'b1;
		@(posedge clk);
		fclr <= 4'h0;
		oclr <= 1'b0;
	endtask

	// Bounded waits sample at the falling edge, where outputs have settled.
	task automatic wait_cnt(input logic [15:0] v);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (cnt !== v && n < 2000);
	endtask

	task automatic step_len(output int k);
		logic [15:0] v;
		v = cnt;
		k = 0;
		while (cnt === v && k < 200) begin
			@(negedge clk);
			k++;
		end
	endtask

	task automatic run_while(input int ch, input logic lvl, output int k);
		k = 0;
		while (pin_out[ch] === lvl && k < 600) begin
			@(negedge clk);
			k++;
		end
	endtask

	// Skips the pulse in progress so a whole high and low phase is timed.
	task automatic pin_meas(input int ch);
		@(negedge clk);
		run_while(ch, 1'b1, n);
		run_while(ch, 1'b0, n);
		run_while(ch, 1'b1, hi);
		run_while(ch, 1'b0, per);
		per += hi;
	endtask

	task automatic give_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run of some ten thousand cycles.
	initial begin
		#1000000;
		failures++;
		give_verdict();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		ticks(12);
		srst <= 1'b0;
		@(negedge clk);
		chk("count after reset", 16'h0000, cnt);
		chk("outputs after reset", 16'h0000, {ovf, oirq, pas, pin_out, flag, irq});
		pins.ext_pulses(5);
		@(negedge clk);
		chk("external count", 16'h0005, cnt);
		ticks(1);
		capm <= 4'hC;
		edg <= 8'h90;
		cie <= 4'hC;
		ticks(6);
		clr_flags();
		pins.set_src(2, 1'b0);
		ticks(6);
		@(negedge clk);
		chk("rise-only channel on falling edge", 16'h0000, 16'(flag));
		pins.ext_pulses(2);
		pins.set_src(2, 1'b1);
		pins.set_src(3, 1'b0);
		ticks(6);
		@(negedge clk);
		chk("capture on rising edge", 16'h0007, chv[47:32]);
		chk("capture on falling edge", 16'h0007, chv[63:48]);
		chk("capture flags and requests", 16'h00CC, {8'h00, flag, irq});
		ticks(1);
		capm <= 4'h0;
		cie <= 4'h0;
		modl <= 16'h0007;
		sel <= 3'h0;
		oie <= 1'b1;
		wait_cnt(16'h0001);
		clr_flags();
		wait_cnt(16'h0007);
		@(negedge clk);
		chk("wrap to zero", 16'h0000, cnt);
		chk("overflow flag and request", 16'h0003, {14'h0, ovf, oirq});
		repeat (8) @(negedge clk);
		chk("modulo period", 16'h0000, cnt);
		for (int s = 1; s <= 6; s++) begin
			ticks(1);
			sel <= 3'(s);
			@(negedge clk);
			step_len(n);
			step_len(n);
			chk("prescaler step", 16'(1 << s), 16'(n));
		end
		ticks(1);
		sel <= 3'h0;
		modl <= 16'h00FF;
		// Clear or set for PWM; the toggle case runs without toggle on overflow.
		for (int i = 0; i < 3; i++) begin
			ticks(1);
			act[1:0] <= 2'(t_act[i]);
			tov[0] <= 1'(t_tov[i]);
			wait_cnt(16'h00FF);
			wr_val(0, 16'(t_val[i]));
			ticks(600);
			pin_meas(0);
			chk("pulse width", 16'(t_hi[i]), 16'(hi));
			chk("pulse period", 16'(t_per[i]), 16'(per));
		end
		for (int p = 0; p < 2; p++) begin
			e = 2 * p;
			ticks(1);
			act <= 8'h02 << (2 * e);
			tov <= 4'h1 << e;
			wr_val(e, 16'h0040);
			ticks(1);
			lnk <= 2'(1 << p);
			ticks(600);
			pin_meas(e);
			chk("buffered even half", 16'h0040, 16'(hi));
			chk("odd pin released", 16'h0000, 16'(pin_oe[e + 1]));
			wr_val(e + 1, 16'h00C0);
			pin_meas(e);
			chk("handover at overflow", 16'h00C0, 16'(hi));
			chk("odd half governs", 16'h0001, 16'(pas[p]));
			wr_val(e, 16'h0020);
			pin_meas(e);
			chk("last written governs", 16'h0020, 16'(hi));
			ticks(1);
			lnk <= 2'h0;
		end
		give_verdict();
	end
endmodule
